// *** atfs_regs.svh ***
`ifndef ATFS_REGS_SVH
`define ATFS_REGS_SVH

// host addresses
`define ATFS_STATUS_ADDR 8'h30
`define ATFS_DATA_ADDR 8'h80

// status field positions
`define ATFS_BIT_FULL 0
`define ATFS_BIT_EMPTY 1
`define ATFS_BIT_ERR 2
`define ATFS_BIT_CLR 3
`define ATFS_BIT_MARKER 4
`define ATFS_BIT_MODE 5
`define ATFS_PTR_LSB 6
`define ATFS_PTR_MSB 14
`define ATFS_FREE_LSB 23
`define ATFS_FREE_MSB 31

// reset value and memory shape
`define ATFS_STATUS_RESET 32'h0000_0000
`define ATFS_DEPTH 512
`define ATFS_DATA_W 32
`define ATFS_FREE_MAX 10'h1ff

`endif

// *** atfs_pkg.sv ***
package atfs_pkg;
   typedef logic [8:0] atfs_ptr_t;
   typedef logic [9:0] atfs_cnt_t;
   // one memory location: marker above 32 data bits
   typedef struct packed {
      logic marker;
      logic [31:0] data;
   } atfs_word_s;
   // what a pending host read returns
   typedef enum logic [1:0] {
      RS_NONE = 2'b00,
      RS_STATUS = 2'b01,
      RS_MEM = 2'b10,
      RS_ZERO = 2'b11
   } atfs_rsrc_e;
endpackage

// *** atfs_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface atfs_mem_if;
   logic we;
   atfs_pkg::atfs_ptr_t waddr;
   atfs_pkg::atfs_word_s wdata;
   logic re;
   atfs_pkg::atfs_ptr_t raddr;
   atfs_pkg::atfs_word_s rdata;
   modport ctrl (output we, output waddr, output wdata, output re, output raddr,
      input rdata);
   modport mem (input we, input waddr, input wdata, input re, input raddr,
      output rdata);
endinterface
`default_nettype wire

// *** atfs_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atfs_regs.svh"
module atfs_mem (
   // clock
   input wire logic clock,
   // access ports
   atfs_mem_if.mem port
);
   atfs_pkg::atfs_word_s store [`ATFS_DEPTH];
   atfs_pkg::atfs_word_s rdata_reg;

   // no reset on the array: contents are undefined until written
   always_ff @(posedge clock) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
      if (port.re) begin
         rdata_reg <= store[port.raddr];
      end
   end
   assign port.rdata = rdata_reg;
endmodule // atfs_mem
`default_nettype wire

// *** atfs_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atfs_regs.svh"
// Functional notes
// - full queue sets full flag; further host writes to it are dropped
// - empty flag in status bit 1 when queue stores nothing
// - every memory location is 33 bits: marker above 32 data bits
// - marker 1 tags first quadlet of a packet (token in receive queue)
// - test-mode read compares stored marker with bit 4; mismatch sets bit 2
// - mismatch error cleared by pointer clear write or leaving test mode
// - pointer clear makes next access hit location 0, then self-clears
// - test-mode write stores bit 4 marker plus data at pointer
// - test-mode read returns location at pointer
// - test mode disables queue; address 80h reaches the pointed location
// - pointer in bits 6-14 steps by one after each test access, 0 to 511
// - bits 23-31 report free quadlets of the queue
// - status register sits at address 30h
// - flags read-only, control fields read/write
module atfs_status (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // host register port
   input wire logic [7:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [31:0] host_wdata,
   input wire logic host_first,
   output logic [31:0] host_rdata,
   output logic host_rvalid,
   // queue allocation in quadlets
   input wire logic [9:0] queue_size,
   // transmitter drain side
   input wire logic tx_pop,
   output logic tx_valid,
   output logic [31:0] tx_data,
   output logic tx_first
);
   atfs_mem_if mif ();
   atfs_mem u_mem (.clock(clock), .port(mif.mem));

   logic mode_reg, mode_next, marker_reg, marker_next, clr_reg, clr_next;
   logic err_reg, err_next, chk_reg, chk_next, chkm_reg, chkm_next;
   logic txv_reg, txv_next, rv_reg, rv_next;
   atfs_pkg::atfs_ptr_t lp_reg, lp_next, wp_reg, wp_next, rp_reg, rp_next;
   atfs_pkg::atfs_cnt_t cnt_reg, cnt_next, free_raw;
   atfs_pkg::atfs_rsrc_e rsrc_reg, rsrc_next;
   logic [31:0] rd_reg, rd_next, stat_reg, stat_next, status;
   logic full, empty, st_wr, st_rd, dat_wr, dat_rd, push, pop, tacc, mism;
   logic [8:0] free_q;
   atfs_pkg::atfs_ptr_t taddr;

   // wrap a queue pointer at the allocated size
   function automatic atfs_pkg::atfs_ptr_t step_ptr(input atfs_pkg::atfs_ptr_t p,
         input atfs_pkg::atfs_cnt_t size);
      if ({1'b0, p} + 10'h001 >= size) begin
         step_ptr = 9'h000;
      end else begin
         step_ptr = p + 9'h001;
      end
   endfunction

   // flags and free space
   assign full = (cnt_reg >= queue_size);
   assign empty = (cnt_reg == 10'h000);
   assign free_raw = full ? 10'h000 : queue_size - cnt_reg;
   // 512 free does not fit nine bits, so the field saturates
   assign free_q = (free_raw > `ATFS_FREE_MAX) ? 9'h1ff : free_raw[8:0];

   // status image; reserved bits read zero
   always_comb begin
      status = `ATFS_STATUS_RESET;
      status[`ATFS_BIT_FULL] = full;
      status[`ATFS_BIT_EMPTY] = empty;
      status[`ATFS_BIT_ERR] = err_reg;
      status[`ATFS_BIT_CLR] = clr_reg;
      status[`ATFS_BIT_MARKER] = marker_reg;
      status[`ATFS_BIT_MODE] = mode_reg;
      status[`ATFS_PTR_MSB:`ATFS_PTR_LSB] = lp_reg;
      status[`ATFS_FREE_MSB:`ATFS_FREE_LSB] = free_q;
   end

   // access decode
   assign st_wr = host_wr && (host_addr == `ATFS_STATUS_ADDR);
   assign st_rd = host_rd && (host_addr == `ATFS_STATUS_ADDR);
   assign dat_wr = host_wr && (host_addr == `ATFS_DATA_ADDR);
   assign dat_rd = host_rd && (host_addr == `ATFS_DATA_ADDR);
   assign tacc = mode_reg && (dat_wr || dat_rd);
   assign taddr = clr_reg ? 9'h000 : lp_reg;
   assign push = !mode_reg && dat_wr && !full;
   assign pop = !mode_reg && tx_pop && !empty;
   assign mism = chk_reg && (mif.rdata.marker != chkm_reg);

   // memory port drive
   always_comb begin
      mif.we = push || (tacc && dat_wr);
      mif.waddr = mode_reg ? taddr : wp_reg;
      mif.wdata.marker = mode_reg ? marker_reg : host_first;
      mif.wdata.data = host_wdata;
      mif.re = pop || (tacc && dat_rd);
      mif.raddr = mode_reg ? taddr : rp_reg;
   end

   // control, pointer and queue next state
   always_comb begin
      mode_next = mode_reg;
      marker_next = marker_reg;
      clr_next = clr_reg;
      err_next = err_reg;
      lp_next = lp_reg;
      wp_next = wp_reg;
      rp_next = rp_reg;
      cnt_next = cnt_reg;
      chk_next = tacc && dat_rd;
      chkm_next = marker_reg;
      if (st_wr) begin
         // only control fields take the write; flags are read-only
         mode_next = host_wdata[`ATFS_BIT_MODE];
         marker_next = host_wdata[`ATFS_BIT_MARKER];
         if (host_wdata[`ATFS_BIT_CLR] || !host_wdata[`ATFS_BIT_MODE]) begin
            err_next = 1'b0;
         end
         if (host_wdata[`ATFS_BIT_CLR]) begin
            clr_next = 1'b1;
         end
         if (host_wdata[`ATFS_BIT_MODE] != mode_reg) begin
            // a mode change leaves queue contents meaningless, so empty it
            wp_next = 9'h000;
            rp_next = 9'h000;
            cnt_next = 10'h000;
         end
      end
      if (tacc) begin
         lp_next = taddr + 9'h001;
         clr_next = 1'b0;
         if (clr_reg) begin
            err_next = 1'b0;
         end
      end
      if (mism) begin
         err_next = 1'b1;
      end
      if (push) begin
         wp_next = step_ptr(wp_reg, queue_size);
      end
      if (pop) begin
         rp_next = step_ptr(rp_reg, queue_size);
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 10'h001;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 10'h001;
      end
   end

   // read return pipeline: select on cycle 1, present on cycle 2
   always_comb begin
      rsrc_next = atfs_pkg::RS_NONE;
      if (st_rd) begin
         rsrc_next = atfs_pkg::RS_STATUS;
      end else if (tacc && dat_rd) begin
         rsrc_next = atfs_pkg::RS_MEM;
      end else if (host_rd) begin
         rsrc_next = atfs_pkg::RS_ZERO;
      end
      stat_next = status;
      rv_next = (rsrc_reg != atfs_pkg::RS_NONE);
      rd_next = rd_reg;
      unique case (rsrc_reg)
         atfs_pkg::RS_NONE: rd_next = rd_reg;
         atfs_pkg::RS_STATUS: rd_next = stat_reg;
         atfs_pkg::RS_MEM: rd_next = mif.rdata.data;
         atfs_pkg::RS_ZERO: rd_next = 32'h0000_0000;
      endcase
      txv_next = pop;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= 1'b0;
         marker_reg <= 1'b0;
         clr_reg <= 1'b0;
         err_reg <= 1'b0;
         chk_reg <= 1'b0;
         chkm_reg <= 1'b0;
         lp_reg <= 9'h000;
         wp_reg <= 9'h000;
         rp_reg <= 9'h000;
         cnt_reg <= 10'h000;
         rsrc_reg <= atfs_pkg::RS_NONE;
         stat_reg <= 32'h0000_0000;
         rd_reg <= 32'h0000_0000;
         rv_reg <= 1'b0;
         txv_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         marker_reg <= marker_next;
         clr_reg <= clr_next;
         err_reg <= err_next;
         chk_reg <= chk_next;
         chkm_reg <= chkm_next;
         lp_reg <= lp_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
         rsrc_reg <= rsrc_next;
         stat_reg <= stat_next;
         rd_reg <= rd_next;
         rv_reg <= rv_next;
         txv_reg <= txv_next;
      end
   end

   assign host_rdata = rd_reg;
   assign host_rvalid = rv_reg;
   assign tx_valid = txv_reg;
   // gated so undefined memory never shows before the first pop
   assign tx_data = txv_reg ? mif.rdata.data : 32'h0000_0000;
   assign tx_first = txv_reg && mif.rdata.marker;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_full_drop: assert property (full && dat_wr && !mode_reg |-> !mif.we)
      else $error("write accepted while queue full");
   a_empty_flag: assert property ((cnt_reg == 10'h000) == status[`ATFS_BIT_EMPTY])
      else $error("empty flag disagrees with count");
   a_mismatch_sets: assert property (tacc && dat_rd && !st_wr ##1
         (mif.rdata.marker != $past(marker_reg)) |=> err_reg)
      else $error("marker mismatch not flagged");
   a_err_clears: assert property (st_wr && !host_wdata[`ATFS_BIT_MODE] && !mism
         |=> !err_reg)
      else $error("error not cleared on leaving test mode");
   a_clear_zero: assert property (clr_reg && tacc |-> mif.waddr == 9'h000 ##1
         (lp_reg == 9'h001 && !clr_reg))
      else $error("pointer clear did not hit location zero");
   a_test_write: assert property (tacc && dat_wr |-> mif.we &&
         mif.wdata.marker == marker_reg)
      else $error("test write lost marker");
   a_read_lat: assert property (st_rd |-> ##2 host_rvalid &&
         host_rdata == $past(status, 2))
      else $error("status read wrong or late");
   a_ptr_step: assert property (tacc && !clr_reg |=> lp_reg == $past(lp_reg) + 9'h001)
      else $error("pointer did not step");
   a_mode_blocks: assert property (mode_reg |-> !push && !pop)
      else $error("queue active in test mode");
   a_free_count: assert property (!full && free_raw <= 10'h1ff |->
         status[`ATFS_FREE_MSB:`ATFS_FREE_LSB] == queue_size[8:0] - cnt_reg[8:0])
      else $error("free count wrong");

   c_fill: cover property (push ##1 full);
   c_mismatch: cover property (mism);
   c_pop: cover property (pop ##1 tx_valid && tx_first);
   c_wrap: cover property (tacc && lp_reg == 9'h1ff);
endmodule // atfs_status
`default_nettype wire

// *** atfs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module atfs_host_model (
   // clock
   input wire logic clock,
   // register port toward the device
   output logic [7:0] host_addr,
   output logic host_wr,
   output logic host_rd,
   output logic [31:0] host_wdata,
   output logic host_first,
   input wire logic [31:0] host_rdata,
   input wire logic host_rvalid
);
   // idle bus at time zero
   initial begin
      host_addr = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 32'h0000_0000;
      host_first = 1'b0;
   end

   // released lines show the inverse, so stale data never passes for fresh
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic f);
      @(posedge clock);
      host_addr <= a;
      host_wdata <= d;
      host_first <= f;
      host_wr <= 1'b1;
      @(posedge clock);
      host_wr <= 1'b0;
      host_addr <= ~a;
      host_wdata <= ~d;
      host_first <= ~f;
   endtask

   // bounded wait for the answer; no answer leaves d unknown
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      d = 'x;
      @(posedge clock);
      host_addr <= a;
      host_rd <= 1'b1;
      @(posedge clock);
      host_rd <= 1'b0;
      host_addr <= ~a;
      for (int n = 0; n < 4; n++) begin
         @(posedge clock);
         if (host_rvalid === 1'b1) begin
            d = host_rdata;
            break;
         end
      end
   endtask
endmodule // atfs_host_model
`default_nettype wire

// *** async_tx_fifo_status_memory_check_mode_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module async_tx_fifo_status_memory_check_mode_test;
   logic clock, rst_n, host_wr, host_rd, host_first, host_rvalid;
   logic tx_pop, tx_valid, tx_first;
   logic [7:0] host_addr;
   logic [31:0] host_wdata, host_rdata, tx_data, v;
   logic [9:0] queue_size;
   int fails = 0;
   int n_compared = 0;

   atfs_status uut (.clock(clock), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_first(host_first),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .queue_size(queue_size),
      .tx_pop(tx_pop), .tx_valid(tx_valid), .tx_data(tx_data), .tx_first(tx_first));
   atfs_host_model host (.clock(clock), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_first(host_first),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid));

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // status image: free count, pointer, six low flag and control bits
   function automatic logic [31:0] st(input logic [8:0] fr, input logic [8:0] p,
      input logic [5:0] lo);
      return {fr, 8'h00, p, lo};
   endfunction

   // one drain request, answer sampled one edge after it is taken
   task automatic pop(input logic [31:0] d, input logic f);
      @(posedge clock);
      tx_pop <= 1'b1;
      @(posedge clock);
      tx_pop <= 1'b0;
      @(posedge clock);
      chk({30'h0, tx_valid, tx_first}, {30'h0, 1'b1, f}, "pop flags");
      chk(tx_data, d, "pop data");
   endtask

   task automatic t_reset;
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h000, 6'h02), "reset status");
      // a queue of 512 has one free quadlet too many for nine bits
      queue_size <= 10'h200;
      host.rd(8'h30, v);
      chk(v, st(9'h1ff, 9'h000, 6'h02), "free count saturates");
      queue_size <= 10'h004;
      // outside test mode the data address and unused addresses read zero
      host.rd(8'h80, v);
      chk(v, 32'h0000_0000, "data read in normal mode");
      host.rd(8'h40, v);
      chk(v, 32'h0000_0000, "unused address read");
   endtask

   // a three-quadlet packet then a one-quadlet packet fill the queue exactly
   task automatic t_fill;
      host.rd(8'h30, v);
      if (v[31:23] > 9'h003) begin
         for (int i = 0; i < 4; i++) begin
            host.wr(8'h80, 32'ha5a5_0000 + i, i == 0 || i == 3);
            host.rd(8'h30, v);
            chk(v, st(9'(3 - i), 9'h000, {5'h00, i == 3}), "fill status");
         end
      end
      host.wr(8'h80, 32'hdead_beef, 1'b1);
      host.rd(8'h30, v);
      chk(v, st(9'h000, 9'h000, 6'h01), "write while full");
      for (int i = 0; i < 4; i++) pop(32'ha5a5_0000 + i, i == 0 || i == 3);
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h000, 6'h02), "drained");
   endtask

   // full sweep of the memory so the pointer wraps back to 0
   task automatic t_ram;
      host.wr(8'h30, 32'h0000_0038, 1'b0);
      for (int i = 0; i < 512; i++) host.wr(8'h80, {i[15:0], ~i[15:0]}, 1'b0);
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h000, 6'h32), "pointer after sweep");
      for (int i = 0; i < 3; i++) begin
         host.rd(8'h80, v);
         chk(v, {i[15:0], ~i[15:0]}, "test read");
      end
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h003, 6'h32), "no mismatch");
      host.wr(8'h30, 32'h0000_0028, 1'b0);
      host.rd(8'h80, v);
      chk(v, 32'h0000_ffff, "read after pointer clear");
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h001, 6'h26), "marker mismatch");
      host.wr(8'h30, 32'h0000_0038, 1'b0);
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h001, 6'h3a), "clear write drops error");
      host.wr(8'h30, 32'h0000_0028, 1'b0);
      host.rd(8'h80, v);
      host.rd(8'h30, v);
      chk(v, st(9'h004, 9'h001, 6'h26), "second mismatch");
      // flag bits written as ones must not stick; pointer is ignored here
      host.wr(8'h30, 32'hffff_ffc7, 1'b0);
      host.rd(8'h30, v);
      chk(v & 32'hffff_803f, 32'h0200_0002, "leave test mode");
   endtask

   task automatic test_done;
      if (fails == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence after 4 cycles of reset
   initial begin
      rst_n = 1'b0;
      tx_pop = 1'b0;
      queue_size = 10'h004;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_fill;
      t_ram;
      test_done;
   end

   // the sequence needs under 3000 cycles, so this only trips on a hang
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      test_done;
   end
endmodule // async_tx_fifo_status_memory_check_mode_test
`default_nettype wire
